// >>> src/ssr_pkg.sv
/*
  Package for the sensor status readout register bank: register indices,
  field positions, reset values, timing constants and carrier structs.
  Assumes a single 250 MHz clock domain and an AXI4-Lite register bus.
*/
package ssr_pkg;

  // ----------------------------------------------------------------------
  // Register indices (printed offsets); byte address is four times these.
  // ----------------------------------------------------------------------
  localparam logic [7:0] TIME_LOW_IDX = 8'h18;
  localparam logic [7:0] TIME_MID_IDX = 8'h19;
  localparam logic [7:0] TIME_HIGH_IDX = 8'h1A;
  localparam logic [7:0] EVENT_FLAGS_IDX = 8'h1B;
  localparam logic [7:0] FEATURE_IRQ_IDX = 8'h1C;
  localparam logic [7:0] DATA_IRQ_IDX = 8'h1D;
  localparam logic [7:0] DIE_TEMP_IDX = 8'h22;
  localparam logic [7:0] QCOUNT_LOW_IDX = 8'h24;
  localparam logic [7:0] QCOUNT_HIGH_IDX = 8'h25;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int POR_BIT = 0;
  localparam int ERR_BIT = 7;
  localparam int NOMO_BIT = 6;
  localparam int ANYMO_BIT = 5;
  localparam int ACCRDY_BIT = 7;
  localparam int AUXRDY_BIT = 5;
  localparam int WMARK_BIT = 1;
  localparam int QFULL_BIT = 0;
  localparam logic [7:0] FEATURE_MASK = 8'hE0;
  localparam logic [7:0] DATA_MASK = 8'hA3;
  localparam logic [7:0] EVENT_RESET = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int QCOUNT_W = 14;
  localparam int TIME_W = 24;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // Timing: base tick of the timestamp.
  // ----------------------------------------------------------------------
  localparam real TICK_NS = 39062.5;
  localparam real CLK_NS = 4.0;
  localparam int TICK_CYCLES = int'(TICK_NS / CLK_NS) < 1 ? 1 :
    int'($floor(TICK_NS / CLK_NS));

  // ----------------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic err;
    logic noMotion;
    logic anyMotion;
    logic accReady;
    logic auxReady;
    logic waterMark;
    logic queueFull;
  } ssr_events_type;

  typedef struct packed {
    logic [7:0] dieTemp;
    logic [QCOUNT_W-1:0] queueCount;
  } ssr_levels_type;

endpackage

// >>> src/ssr_status_regs.sv
/*
  Read-only status register bank of a motion sensor: a free-running 24-bit
  timestamp, a power-up flag, two clear-on-read interrupt status bytes, a
  die temperature byte and a 14-bit queue fill count, read over AXI4-Lite.
  Assumes event pulses, temperature and fill count come from logic on mclk.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Timestamp bits 7..0 are readable, one count being 39.0625 us.
// - Timestamp bits 15..8 read in their own byte, zero after reset.
// - Timestamp bits 23..16 read in their own byte.
// - The power-up flag sets at reset (byte 0x01) and clears on read.
// - Feature status holds error, no-motion, any-motion; read clears.
// - Data status holds data-ready, aux-ready, watermark, full; read clears.
// - Temperature reads as two's complement kelvin steps, 0 is 23 C.
// - The low count byte holds queue fill count bits 7..0.
// - The high count byte holds count bits 13..8, bits 7..6 read zero.
module ssr_status_regs #(
  parameter int TICK_DIV = ssr_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Event pulses and live levels from the sensor core.
  input wire ssr_pkg::ssr_events_type events,
  input wire ssr_pkg::ssr_levels_type levels,
  // AXI4-Lite write address and data.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [ssr_pkg::TIME_W-1:0] stamp;
    logic por;
    logic [7:0] featIrq;
    logic [7:0] dataIrq;
    logic awHeld;
    logic wHeld;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
  } ssr_state_type;

  ssr_state_type s_q, s_d;
  logic tick;
  logic [7:0] featSet;
  logic [7:0] dataSet;
  logic [7:0] rdIndex;
  logic rdTake;
  logic rdMapped;
  logic [7:0] rdByte;

  ssr_tick_divider #(
    .DIVIDE(TICK_DIV)
  ) u_div (
    .mclk(mclk),
    .nrst(nrst),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Event byte assembly.
  // ----------------------------------------------------------------------
  always_comb begin
    featSet = ssr_pkg::BYTE_ZERO;
    featSet[ssr_pkg::ERR_BIT] = events.err;
    featSet[ssr_pkg::NOMO_BIT] = events.noMotion;
    featSet[ssr_pkg::ANYMO_BIT] = events.anyMotion;
    dataSet = ssr_pkg::BYTE_ZERO;
    dataSet[ssr_pkg::ACCRDY_BIT] = events.accReady;
    dataSet[ssr_pkg::AUXRDY_BIT] = events.auxReady;
    dataSet[ssr_pkg::WMARK_BIT] = events.waterMark;
    dataSet[ssr_pkg::QFULL_BIT] = events.queueFull;
  end

  // ----------------------------------------------------------------------
  // Read decode.
  // ----------------------------------------------------------------------
  // Multi-byte values are not captured together: a tick may fall between
  // two byte reads of the timestamp, so software must allow for a carry.
  assign rdIndex = s_axi_araddr[ssr_pkg::ADDR_LSB +: 8];
  assign rdTake = s_axi_arvalid && !s_q.rValid;

  always_comb begin
    rdMapped = 1'b1;
    rdByte = ssr_pkg::BYTE_ZERO;
    if (rdIndex == ssr_pkg::TIME_LOW_IDX) begin
      rdByte = s_q.stamp[7:0];
    end else if (rdIndex == ssr_pkg::TIME_MID_IDX) begin
      rdByte = s_q.stamp[15:8];
    end else if (rdIndex == ssr_pkg::TIME_HIGH_IDX) begin
      rdByte = s_q.stamp[23:16];
    end else if (rdIndex == ssr_pkg::EVENT_FLAGS_IDX) begin
      rdByte[ssr_pkg::POR_BIT] = s_q.por;
    end else if (rdIndex == ssr_pkg::FEATURE_IRQ_IDX) begin
      rdByte = s_q.featIrq & ssr_pkg::FEATURE_MASK;
    end else if (rdIndex == ssr_pkg::DATA_IRQ_IDX) begin
      rdByte = s_q.dataIrq & ssr_pkg::DATA_MASK;
    end else if (rdIndex == ssr_pkg::DIE_TEMP_IDX) begin
      rdByte = levels.dieTemp;
    end else if (rdIndex == ssr_pkg::QCOUNT_LOW_IDX) begin
      rdByte = levels.queueCount[7:0];
    end else if (rdIndex == ssr_pkg::QCOUNT_HIGH_IDX) begin
      rdByte = {2'b00, levels.queueCount[13:8]};
    end else begin
      rdMapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Wraps naturally at the 24-bit maximum; no write path exists.
    if (tick) begin
      s_d.stamp = s_q.stamp + 24'h00_0001;
    end
    // Clear on read first, so a same-cycle event still sets the bit.
    if (rdTake && rdIndex == ssr_pkg::EVENT_FLAGS_IDX) begin
      s_d.por = 1'b0;
    end
    if (rdTake && rdIndex == ssr_pkg::FEATURE_IRQ_IDX) begin
      s_d.featIrq = ssr_pkg::BYTE_ZERO;
    end
    if (rdTake && rdIndex == ssr_pkg::DATA_IRQ_IDX) begin
      s_d.dataIrq = ssr_pkg::BYTE_ZERO;
    end
    s_d.featIrq = s_d.featIrq | featSet;
    s_d.dataIrq = s_d.dataIrq | dataSet;

    // Writes: every register is read-only, so writes answer SLVERR.
    if (s_axi_awvalid && !s_q.awHeld && !s_q.bValid) begin
      s_d.awHeld = 1'b1;
    end
    if (s_axi_wvalid && !s_q.wHeld && !s_q.bValid) begin
      s_d.wHeld = 1'b1;
    end
    if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
      s_d.bValid = 1'b1;
      s_d.bResp = ssr_pkg::RESP_SLVERR;
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end

    if (rdTake) begin
      s_d.rValid = 1'b1;
      s_d.rData = {24'h00_0000, rdByte};
      s_d.rResp = rdMapped ? ssr_pkg::RESP_OKAY : ssr_pkg::RESP_SLVERR;
    end else if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.por <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Bus outputs.
  // ----------------------------------------------------------------------
  assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
  assign s_axi_wready = !s_q.wHeld && !s_q.bValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;

  // ----------------------------------------------------------------------
  // Checks on register contents.
  // ----------------------------------------------------------------------
  stamp_step_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    tick |=> s_q.stamp == $past(s_q.stamp) + 24'h00_0001)
    else $error("timestamp did not advance on tick");

  stamp_hold_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    !tick |=> $stable(s_q.stamp))
    else $error("timestamp moved without tick");

  low_read_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::TIME_LOW_IDX
      |=> s_axi_rdata[7:0] == $past(s_q.stamp[7:0]))
    else $error("timestamp low byte mismatch");

  mid_read_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::TIME_MID_IDX
      |=> s_axi_rdata[7:0] == $past(s_q.stamp[15:8]))
    else $error("timestamp mid byte mismatch");

  high_read_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::TIME_HIGH_IDX
      |=> s_axi_rdata[7:0] == $past(s_q.stamp[23:16]))
    else $error("timestamp high byte mismatch");

  por_clear_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::EVENT_FLAGS_IDX
      |=> !s_q.por && s_axi_rdata[7:0] == {7'h00, $past(s_q.por)})
    else $error("power-up flag not cleared on read");

  por_stay_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    !s_q.por |=> !s_q.por)
    else $error("power-up flag set again without reset");

  feat_set_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    featSet != ssr_pkg::BYTE_ZERO
      |=> (s_q.featIrq & $past(featSet)) == $past(featSet))
    else $error("feature event lost");

  feat_clear_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::FEATURE_IRQ_IDX
      |=> s_q.featIrq == $past(featSet))
    else $error("feature status not cleared on read");

  feat_hold_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(rdTake && rdIndex == ssr_pkg::FEATURE_IRQ_IDX)
      |=> (s_q.featIrq & $past(s_q.featIrq)) == $past(s_q.featIrq))
    else $error("feature status dropped without read");

  feat_read_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::FEATURE_IRQ_IDX
      |=> s_axi_rdata[7:0] == $past(s_q.featIrq))
    else $error("feature status read mismatch");

  data_set_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    events.queueFull |=> s_q.dataIrq[ssr_pkg::QFULL_BIT])
    else $error("queue full event lost");

  data_clear_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::DATA_IRQ_IDX
      |=> s_q.dataIrq == $past(dataSet))
    else $error("data status not cleared on read");

  data_hold_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(rdTake && rdIndex == ssr_pkg::DATA_IRQ_IDX)
      |=> (s_q.dataIrq & $past(s_q.dataIrq)) == $past(s_q.dataIrq))
    else $error("data status dropped without read");

  data_read_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::DATA_IRQ_IDX
      |=> s_axi_rdata[7:0] == $past(s_q.dataIrq))
    else $error("data status read mismatch");

  temp_read_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::DIE_TEMP_IDX
      |=> s_axi_rdata[7:0] == $past(levels.dieTemp))
    else $error("temperature read mismatch");

  count_low_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::QCOUNT_LOW_IDX
      |=> s_axi_rdata[7:0] == $past(levels.queueCount[7:0]))
    else $error("count low byte mismatch");

  count_high_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdIndex == ssr_pkg::QCOUNT_HIGH_IDX
      |=> s_axi_rdata[7:0] == {2'b00, $past(levels.queueCount[13:8])})
    else $error("count high byte mismatch");

  // ----------------------------------------------------------------------
  // Checks on the bus handshake.
  // ----------------------------------------------------------------------
  rdata_upper_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bytes nonzero");

  read_answer_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && rdMapped
      |=> s_axi_rvalid && s_axi_rresp == ssr_pkg::RESP_OKAY)
    else $error("mapped read not answered okay");

  unmapped_read_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rdTake && !rdMapped
      |=> s_axi_rvalid && s_axi_rresp == ssr_pkg::RESP_SLVERR
        && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  read_drop_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");

  write_err_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axi_bvalid |-> s_axi_bresp == ssr_pkg::RESP_SLVERR)
    else $error("write not refused");

  write_answer_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_q.awHeld && s_q.wHeld && !s_q.bValid
      |=> s_axi_bvalid)
    else $error("write response missing");

  write_drop_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");

endmodule // ssr_status_regs

// >>> src/ssr_tick_divider.sv
/*
  Divider that produces the one-cycle timestamp base tick enable.
  Assumes the same clock and synchronous reset as its parent.
*/
`timescale 1ns/1ps
module ssr_tick_divider #(
  parameter int DIVIDE = ssr_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Tick enable.
  output logic tick
);

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } ssr_div_state_type;

  ssr_div_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.count == 32'(DIVIDE - 1)) begin
      s_d.count = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.count = s_q.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule // ssr_tick_divider

// >>> verification/ssr_host_model.sv
/*
  Host model: an AXI4-Lite master with one read task and one write task.
  Assumes the register bank's answers settle before each falling edge.
*/
`timescale 1ns/1ps
module ssr_host_model (
  // Clock.
  input wire logic mclk,
  // Write channels.
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels.
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic timedOut = 1'b0;

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Ready and valid only move at rising edges, so the falling edge sees
  // exactly what the next rising edge will sample.
  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    bit hs;
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk) hs = s_axi_arready;
      @(posedge mclk) n++;
    end while (!hs && n < 50);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk) hs = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk) n++;
    end while (!hs && n < 50);
    timedOut = timedOut | !hs;
  endtask

  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] r);
    bit aw;
    bit w;
    bit hs;
    int n;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    {aw, w, n} = '0;
    do begin
      @(negedge mclk) aw = aw | (s_axi_awvalid & s_axi_awready);
      w = w | (s_axi_wvalid & s_axi_wready);
      hs = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk) n++;
      if (aw && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!hs && n < 50);
    timedOut = timedOut | !hs;
  endtask
endmodule // ssr_host_model

// >>> verification/ssr_status_regs_tb.sv
/*
  Self-checking bench for the status register bank, driven by the host
  model. Assumes a shortened tick divider of four clocks.
*/
`timescale 1ns/1ps
module ssr_status_regs_tb;
  localparam int DIV = 4;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  ssr_pkg::ssr_events_type events = '0;
  ssr_pkg::ssr_levels_type levels = '0;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData, d1, d2;
  logic [1:0] bResp, rResp, resp;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [7:0] expBit [7] = '{8'h01, 8'h02, 8'h20, 8'h80, 8'h20, 8'h40, 8'h80};
  int fails = 0;
  int totalChecks = 0;
  int cyc = 0;

  always #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= nrst ? cyc + 1 : 0;

  ssr_status_regs #(.TICK_DIV(DIV)) uut (.mclk(mclk), .nrst(nrst),
    .events(events), .levels(levels), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady));

  ssr_host_model host (.mclk(mclk), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    host.axiRead(ba(idx), d, resp);
    if (host.timedOut) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic rdChk(input string what, input logic [7:0] idx,
    input logic [7:0] e);
    rd(idx, d1);
    check(what, d1, {24'h00_0000, e});
    check("rresp", 32'(resp), 32'(ssr_pkg::RESP_OKAY));
  endtask

  task automatic pulse(input ssr_pkg::ssr_events_type e);
    events <= e;
    @(posedge mclk);
    events <= '0;
  endtask

  task automatic doReset();
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  initial begin
    doReset();
    rdChk("event", ssr_pkg::EVENT_FLAGS_IDX, 8'h01);
    rdChk("event", ssr_pkg::EVENT_FLAGS_IDX, 8'h00);
    rdChk("time mid", ssr_pkg::TIME_MID_IDX, 8'h00);
    rdChk("time high", ssr_pkg::TIME_HIGH_IDX, 8'h00);
    rd(ssr_pkg::TIME_LOW_IDX, d2);
    // Each read returns two edges after its call, so the two samples lie
    // exactly ten tick periods apart whatever the divider phase.
    repeat (10 * DIV - 2) @(posedge mclk);
    rd(ssr_pkg::TIME_LOW_IDX, d1);
    check("tick span", 32'(8'(d1[7:0] - d2[7:0])), 32'h0000_000A);
    for (int i = 0; i < 7; i++) begin
      pulse(ssr_pkg::ssr_events_type'(7'(1 << i)));
      if (i >= 4) begin
        rdChk("feature", ssr_pkg::FEATURE_IRQ_IDX, expBit[i]);
        rdChk("feature", ssr_pkg::FEATURE_IRQ_IDX, 8'h00);
      end else begin
        rdChk("data", ssr_pkg::DATA_IRQ_IDX, expBit[i]);
        rdChk("data", ssr_pkg::DATA_IRQ_IDX, 8'h00);
      end
    end
    pulse(7'h7F);
    rdChk("feature all", ssr_pkg::FEATURE_IRQ_IDX, 8'hE0);
    rdChk("data all", ssr_pkg::DATA_IRQ_IDX, 8'hA3);
    levels <= '{dieTemp: 8'hF6, queueCount: 14'h2A5B};
    rdChk("temp", ssr_pkg::DIE_TEMP_IDX, 8'hF6);
    rdChk("count low", ssr_pkg::QCOUNT_LOW_IDX, 8'h5B);
    rdChk("count high", ssr_pkg::QCOUNT_HIGH_IDX, 8'h2A);
    levels <= '{dieTemp: 8'h00, queueCount: 14'h3FFF};
    rdChk("count high", ssr_pkg::QCOUNT_HIGH_IDX, 8'h3F);
    // Stamp is near cyc/4 here, so bits 15..8 must read one.
    for (int n = 0; n < 2000 && cyc < 1100; n++) @(posedge mclk);
    rdChk("time mid", ssr_pkg::TIME_MID_IDX, 8'h01);
    host.axiWrite(ba(ssr_pkg::TIME_MID_IDX), 32'hFFFF_FFFF, resp);
    check("bresp", 32'(resp), 32'(ssr_pkg::RESP_SLVERR));
    rdChk("time mid", ssr_pkg::TIME_MID_IDX, 8'h01);
    host.axiRead(12'h000, d1, resp);
    check("unmapped", {d1[29:0], resp}, 32'(ssr_pkg::RESP_SLVERR));
    doReset();
    rdChk("event", ssr_pkg::EVENT_FLAGS_IDX, 8'h01);
    if (host.timedOut) fails++;
    end_sim();
  end
endmodule // ssr_status_regs_tb
